// >>> rtl/eetw_pkg.sv
// Purpose: shared constants, types and timing for the two-wire EEPROM target
// Assumes: core clock 40 MHz, link sampling clock period 12 ns
// Notes: every count is derived from a time in its own unit
`default_nettype none

package eetw_pkg;

   // address geometry
   localparam int WORD_W = 8;
   localparam int BLOCK_W = 3;
   localparam int PAGE_W = 4;
   localparam int ADDR_W = BLOCK_W + WORD_W;
   localparam int PAGE_BYTES = 16;
   localparam int BLOCK_BYTES = 256;
   localparam int NUM_BLOCKS = 8;
   localparam int MEM_BYTES = NUM_BLOCKS * BLOCK_BYTES;

   // target address byte layout, msb first
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int BLK_MSB = 3;
   localparam int BLK_LSB = 1;
   localparam int RW_POS = 0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [PAGE_W-1:0] PAGE_LAST = 4'hf;

   // arbitrary value, replace with the real type identifier
   localparam logic [3:0] DEF_TYPE_ID = 4'h5;

   // pin index in the sampled pin vector
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam logic [1:0] PINS_IDLE = 2'h3;

   // noise suppression, least rejection width rounds up
   localparam int NOISE_STD_NS = 100;
   localparam int NOISE_FAST_NS = 50;
   localparam int LINK_PERIOD_NS = 12;
   localparam int FILT_STD_CYCLES = (NOISE_STD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int FILT_FAST_CYCLES = (NOISE_FAST_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int FILT_W = 4;

   // self-timed write cycle, longest time rounds down
   localparam int TWR_STD_MS = 10;
   localparam int TWR_LV_MS = 15;
   localparam int CORE_CLK_KHZ = 40000;
   localparam int TWR_STD_CYCLES = TWR_STD_MS * CORE_CLK_KHZ;
   localparam int TWR_LV_CYCLES = TWR_LV_MS * CORE_CLK_KHZ;
   localparam int TWR_W = 20;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_TX_ACK
   } eetwState_e;

   typedef enum logic [1:0] {
      PH_DEV,
      PH_WORD,
      PH_DATA,
      PH_READ
   } eetwPhase_e;

   // one received write byte on its way to the page latch
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } eetwWrEntry_s;

endpackage

`default_nettype wire

// >>> rtl/eetw_pair_buffer.sv
// Purpose: small valid/ready buffer between byte receiver and page latch
// Assumes: single clock, synchronous active-low reset
// Notes: fillReady drops when full, the caller must honour it
`timescale 1ns/1ps
`default_nettype none

module eetw_pair_buffer #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstN,
   // filling side
   input wire logic fillValid,
   output logic fillReady,
   input wire logic [WIDTH-1:0] fillData,
   // draining side
   output logic drainValid,
   input wire logic drainReady,
   output logic [WIDTH-1:0] drainData
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   logic [WIDTH-1:0] slot_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   wire push = fillValid & fillReady;
   wire pop = drainValid & drainReady;

   assign fillReady = (cnt_q != CW'(DEPTH));
   assign drainValid = (cnt_q != '0);
   assign drainData = slot_q[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         slot_q[wr_q] <= fillData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstN) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end

endmodule // eetw_pair_buffer

`default_nettype wire

// >>> rtl/eetw_two_wire_target.sv
// Purpose: two-wire serial EEPROM target, 8 page blocks of 256 bytes
// Assumes: linkClk samples the bus pins, core_clk times the write cycle
// Notes: the bus pins are asynchronous to both clocks
`timescale 1ns/1ps
`default_nettype none

module eetw_two_wire_target #(
   parameter logic [3:0] TYPE_ID = eetw_pkg::DEF_TYPE_ID,
   parameter bit FAST_GRADE = 1'b0,
   parameter bit LOW_VOLTAGE = 1'b0,
   parameter int WRITE_CYCLES_STD = eetw_pkg::TWR_STD_CYCLES,
   parameter int WRITE_CYCLES_LV = eetw_pkg::TWR_LV_CYCLES
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // link sampling clock
   input wire logic linkClk,
   // two-wire pins, sda is open drain
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // status
   output logic writeBusy
);

   import eetw_pkg::*;

   localparam int FILT_CYCLES = FAST_GRADE ? FILT_FAST_CYCLES : FILT_STD_CYCLES;
   localparam int WR_CYCLES = LOW_VOLTAGE ? WRITE_CYCLES_LV : WRITE_CYCLES_STD;

   // next byte address; writes roll over inside the page, reads run on
   function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a, input logic inPage);
      logic [PAGE_W-1:0] low;
      low = a[PAGE_W-1:0] + 1'b1;
      nextAddr = inPage ? {a[ADDR_W-1:PAGE_W], low} : a + 1'b1;
   endfunction

   // ---------------- core domain: write cycle timer ----------------
   logic linkReq_q;
   logic [1:0] reqSync_q;
   logic [TWR_W-1:0] wrTimer_q;
   logic coreBusy_q;
   logic coreDone_q;
   wire reqCore = reqSync_q[1];

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         reqSync_q <= '0;
      end else begin
         reqSync_q <= {reqSync_q[0], linkReq_q};
      end
   end

   // four-phase handshake: req up, timer runs, done up, req down, done down
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wrTimer_q <= '0;
         coreBusy_q <= 1'b0;
         coreDone_q <= 1'b0;
      end else if (reqCore && !coreBusy_q && !coreDone_q) begin
         coreBusy_q <= 1'b1;
         wrTimer_q <= TWR_W'(WR_CYCLES - 1);
      end else if (coreBusy_q) begin
         if (wrTimer_q == '0) begin
            coreBusy_q <= 1'b0;
            coreDone_q <= 1'b1;
         end else begin
            wrTimer_q <= wrTimer_q - 1'b1;
         end
      end else if (!reqCore) begin
         coreDone_q <= 1'b0;
      end
   end

   assign writeBusy = coreBusy_q;

   // ---------------- link domain: reset, pins, filter ----------------
   logic [1:0] lrst_q;
   logic [1:0] doneSync_q;
   logic [1:0] pinSync1_q;
   logic [1:0] pinSync2_q;
   logic [1:0] flt_q;
   logic [1:0] fltPrev_q;
   logic [FILT_W-1:0] fltCnt_q [2];
   wire linkRstN = lrst_q[1];
   wire doneLink = doneSync_q[1];

   // reset reaches the link domain through two flops; no reset of its own
   always_ff @(posedge linkClk) begin
      lrst_q <= {lrst_q[0], nrst};
   end

   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         doneSync_q <= '0;
         pinSync1_q <= PINS_IDLE;
         pinSync2_q <= PINS_IDLE;
      end else begin
         doneSync_q <= {doneSync_q[0], coreDone_q};
         pinSync1_q <= {sdaIn, sclIn};
         pinSync2_q <= pinSync1_q;
      end
   end

   // a level must differ for FILT_CYCLES samples in a row before it is taken
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         flt_q <= PINS_IDLE;
         fltPrev_q <= PINS_IDLE;
         for (int i = 0; i < 2; i++) begin
            fltCnt_q[i] <= '0;
         end
      end else begin
         fltPrev_q <= flt_q;
         for (int i = 0; i < 2; i++) begin
            if (pinSync2_q[i] == flt_q[i]) begin
               fltCnt_q[i] <= '0;
            end else if (fltCnt_q[i] == FILT_W'(FILT_CYCLES - 1)) begin
               flt_q[i] <= pinSync2_q[i];
               fltCnt_q[i] <= '0;
            end else begin
               fltCnt_q[i] <= fltCnt_q[i] + 1'b1;
            end
         end
      end
   end

   wire sclF = flt_q[PIN_SCL];
   wire sdaF = flt_q[PIN_SDA];
   wire sclP = fltPrev_q[PIN_SCL];
   wire sdaP = fltPrev_q[PIN_SDA];
   wire sclRise = sclF & ~sclP;
   wire sclFall = ~sclF & sclP;
   wire startEv = sclF & sclP & sdaP & ~sdaF;
   wire stopEv = sclF & sclP & ~sdaP & sdaF;

   // ---------------- link domain: byte engine ----------------
   eetwState_e state_q;
   eetwPhase_e phase_q;
   logic [2:0] bitCnt_q;
   logic [WORD_W-1:0] rxShift_q;
   logic [WORD_W-1:0] txShift_q;
   logic [ADDR_W-1:0] addr_q;
   logic [BLOCK_W-1:0] block_q;
   logic ackDrive_q;
   logic ackHalf_q;
   logic driveLow_q;
   logic wrPending_q;
   logic commitActive_q;
   logic [PAGE_W-1:0] commitIdx_q;
   logic [WORD_W-1:0] mem [MEM_BYTES];

   wire linkBusy = linkReq_q | doneLink;
   wire [WORD_W-1:0] rxByte = {rxShift_q[WORD_W-2:0], sdaF};
   wire [BLOCK_W-1:0] rxBlock = rxByte[BLK_MSB:BLK_LSB];
   wire rxRead = (rxByte[RW_POS] == DIR_READ);
   wire devMatch = (rxByte[TYPE_MSB:TYPE_LSB] == TYPE_ID) & ~linkBusy;
   wire byteDone = (state_q == ST_RX) & sclRise & (bitCnt_q == BIT_LAST);
   wire [ADDR_W-1:0] readAddr = {rxBlock, addr_q[WORD_W-1:0]};
   wire [ADDR_W-1:0] readNext = nextAddr(addr_q, 1'b0);

   // write bytes into the buffer; a full buffer makes the byte unacknowledged
   eetwWrEntry_s fillEntry;
   eetwWrEntry_s drainEntry;
   logic fillReady;
   logic drainValid;
   wire fillValid = byteDone & (phase_q == PH_DATA) & ~startEv & ~stopEv;
   wire drainReady = ~commitActive_q;
   assign fillEntry = '{addr: addr_q, data: rxByte};

   eetw_pair_buffer #(
      .WIDTH($bits(eetwWrEntry_s)),
      .DEPTH(2)
   ) u_buffer (
      .clk(linkClk),
      .rstN(linkRstN),
      .fillValid(fillValid),
      .fillReady(fillReady),
      .fillData(fillEntry),
      .drainValid(drainValid),
      .drainReady(drainReady),
      .drainData(drainEntry)
   );

   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         state_q <= ST_IDLE;
         phase_q <= PH_DEV;
         bitCnt_q <= '0;
         rxShift_q <= '0;
         txShift_q <= '0;
         addr_q <= '0;
         block_q <= '0;
         ackDrive_q <= 1'b0;
         ackHalf_q <= 1'b0;
         driveLow_q <= 1'b0;
         wrPending_q <= 1'b0;
      end else if (startEv) begin
         state_q <= ST_RX;
         phase_q <= PH_DEV;
         bitCnt_q <= '0;
         ackHalf_q <= 1'b0;
         driveLow_q <= 1'b0;
         wrPending_q <= 1'b0;
      end else if (stopEv) begin
         state_q <= ST_IDLE;
         driveLow_q <= 1'b0;
         wrPending_q <= 1'b0;
      end else begin
         unique case (state_q)
            // idle ignores everything until a START
            ST_IDLE: begin
               driveLow_q <= 1'b0;
            end
            ST_RX: begin
               if (sclRise) begin
                  rxShift_q <= rxByte;
                  bitCnt_q <= bitCnt_q + 1'b1;
                  if (bitCnt_q == BIT_LAST) begin
                     ackHalf_q <= 1'b0;
                     state_q <= ST_ACK;
                     if (phase_q == PH_DEV) begin
                        ackDrive_q <= 1'b1;
                        block_q <= rxBlock;
                        phase_q <= rxRead ? PH_READ : PH_WORD;
                        if (rxRead) begin
                           addr_q <= readAddr;
                           txShift_q <= mem[readAddr];
                        end
                        if (!devMatch) begin
                           state_q <= ST_IDLE;
                        end
                     end else if (phase_q == PH_WORD) begin
                        addr_q <= {block_q, rxByte};
                        ackDrive_q <= 1'b1;
                        phase_q <= PH_DATA;
                     end else begin
                        ackDrive_q <= fillReady;
                        if (fillReady) begin
                           addr_q <= nextAddr(addr_q, 1'b1);
                           wrPending_q <= 1'b1;
                        end
                     end
                  end
               end
            end
            // first fall drives the acknowledge, second fall ends the 9th clock
            ST_ACK: begin
               if (sclFall) begin
                  if (!ackHalf_q) begin
                     driveLow_q <= ackDrive_q;
                     ackHalf_q <= 1'b1;
                  end else begin
                     ackHalf_q <= 1'b0;
                     bitCnt_q <= '0;
                     if (!ackDrive_q) begin
                        driveLow_q <= 1'b0;
                        state_q <= ST_IDLE;
                     end else if (phase_q == PH_READ) begin
                        driveLow_q <= ~txShift_q[WORD_W-1];
                        state_q <= ST_TX;
                     end else begin
                        driveLow_q <= 1'b0;
                        state_q <= ST_RX;
                     end
                  end
               end
            end
            ST_TX: begin
               if (sclRise) begin
                  txShift_q <= {txShift_q[WORD_W-2:0], 1'b0};
                  bitCnt_q <= bitCnt_q + 1'b1;
                  if (bitCnt_q == BIT_LAST) begin
                     state_q <= ST_TX_ACK;
                  end
               end else if (sclFall) begin
                  driveLow_q <= ~txShift_q[WORD_W-1];
               end
            end
            ST_TX_ACK: begin
               if (sclFall) begin
                  driveLow_q <= 1'b0;
               end else if (sclRise) begin
                  bitCnt_q <= '0;
                  addr_q <= readNext;
                  if (!sdaF) begin
                     txShift_q <= mem[readNext];
                     state_q <= ST_TX;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ---------------- link domain: page latch and commit ----------------
   logic [WORD_W-1:0] pageData_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pageMask_q;
   logic [ADDR_W-PAGE_W-1:0] pageBase_q;
   wire drainTake = drainValid & drainReady;
   wire commitEnd = commitActive_q & (commitIdx_q == PAGE_LAST);
   wire stopWrite = stopEv & wrPending_q;
   // a START outside the write cycle drops an unfinished page
   wire pageClear = commitEnd | (startEv & ~linkReq_q);
   wire [PAGE_BYTES-1:0] pageSet = drainTake ? (PAGE_BYTES'(1) << drainEntry.addr[PAGE_W-1:0]) : '0;

   always_ff @(posedge linkClk) begin
      if (drainTake) begin
         pageData_q[drainEntry.addr[PAGE_W-1:0]] <= drainEntry.data;
      end
   end

   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         pageMask_q <= '0;
         pageBase_q <= '0;
      end else begin
         pageMask_q <= (pageMask_q & ~(pageClear ? '1 : PAGE_BYTES'(0))) | pageSet;
         if (drainTake) begin
            pageBase_q <= drainEntry.addr[ADDR_W-1:PAGE_W];
         end
      end
   end

   // the latched bytes of the page are programmed when the timed cycle finishes
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         linkReq_q <= 1'b0;
         commitActive_q <= 1'b0;
         commitIdx_q <= '0;
      end else if (stopWrite && !linkBusy) begin
         linkReq_q <= 1'b1;
      end else if (commitActive_q) begin
         commitIdx_q <= commitIdx_q + 1'b1;
         if (commitEnd) begin
            commitActive_q <= 1'b0;
            linkReq_q <= 1'b0;
         end
      end else if (linkReq_q && doneLink) begin
         commitActive_q <= 1'b1;
         commitIdx_q <= '0;
      end
   end

   // memory content has no reset, like the array it models
   always_ff @(posedge linkClk) begin
      if (commitActive_q && pageMask_q[commitIdx_q]) begin
         mem[{pageBase_q, commitIdx_q}] <= pageData_q[commitIdx_q];
      end
   end

   // open drain: only ever pulls low, the enable is low while pulling
   assign sdaOut = 1'b0;
   assign sdaOe = ~driveLow_q;

endmodule // eetw_two_wire_target

`default_nettype wire

// >>> tb/eetw_target_monitor.sv
// Purpose: concurrent checks on the two-wire target pins
// Assumes: controller phases last at least 20 link samples
// Notes: helper counters qualify raw pin edges, so short glitches never count
`timescale 1ns/1ps
`default_nettype none

module eetw_target_monitor #(
   parameter logic [3:0] TYPE_ID = 4'h0,
   parameter int WRITE_CYCLES = 400
) (
   // clocks and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic linkClk,
   // bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // status
   input wire logic writeBusy
);
   logic [4:0] sclHi_q, sdaLo_q, sdaHi_q;
   logic [7:0] rises_q, sinceStop_q, shift_q;
   logic drove_q;
   int busyCnt_q;
   wire logic rise = sclHi_q == 5'd10;
   wire logic busStart = sdaLo_q == 5'd10 && sclHi_q >= 5'd20;
   wire logic busStop = sdaHi_q == 5'd4 && sclHi_q >= 5'd20;

   always_ff @(posedge linkClk) begin
      // counters start from a known level so the first frame is judged too
      sclHi_q <= !nrst || !sclIn ? 5'd0 : sclHi_q + {4'h0, sclHi_q != 5'h1f};
      sdaLo_q <= !nrst || sdaIn ? 5'd0 : sdaLo_q + {4'h0, sdaLo_q != 5'h1f};
      sdaHi_q <= !nrst || !sdaIn ? 5'd0 : sdaHi_q + {4'h0, sdaHi_q != 5'h1f};
      rises_q <= !nrst || busStart ? 8'h0 : rises_q + {7'h0, rise};
      shift_q <= rise ? {shift_q[6:0], sdaIn} : shift_q;
      drove_q <= !nrst || busStart ? 1'b0 : drove_q | $fell(sdaOe);
      sinceStop_q <= !nrst || busStop ? 8'h0 : sinceStop_q + {7'h0, sinceStop_q != 8'hff};
   end

   always_ff @(posedge core_clk) begin
      busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
   end

   sequence s_pull;
      !sdaOe [*8];
   endsequence

   a_od_low: assert property (@(posedge linkClk) disable iff (!nrst) sdaOut == 1'b0)
      else $error("data output not held low");
   a_ack_eighth: assert property (@(posedge linkClk) disable iff (!nrst)
      $fell(sdaOe) && !drove_q |-> rises_q == 8'd8) else $error("first pull not after 8 clocks");
   a_pull_holds: assert property (@(posedge linkClk) disable iff (!nrst)
      $fell(sdaOe) |-> s_pull) else $error("pull released too soon");
   a_edge_scl_low: assert property (@(posedge linkClk) disable iff (!nrst)
      $changed(sdaOe) |-> !sclIn) else $error("data moved while clock high");
   a_type_nack: assert property (@(posedge linkClk) disable iff (!nrst)
      !drove_q && rises_q == 8'd8 && shift_q[7:4] != TYPE_ID |-> sdaOe) else $error("foreign type acked");
   a_busy_released: assert property (@(posedge core_clk) disable iff (!nrst)
      writeBusy |-> sdaOe) else $error("data pulled during write cycle");
   a_busy_length: assert property (@(posedge core_clk) disable iff (!nrst)
      $fell(writeBusy) |-> busyCnt_q inside {[WRITE_CYCLES - 1:WRITE_CYCLES + 4]})
      else $error("write cycle length wrong");
   a_busy_after_stop: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(writeBusy) |-> sinceStop_q < 8'd60) else $error("write cycle not started by stop");
endmodule // eetw_target_monitor

bind eetw_two_wire_target eetw_target_monitor #(
   .TYPE_ID(TYPE_ID),
   .WRITE_CYCLES(LOW_VOLTAGE ? WRITE_CYCLES_LV : WRITE_CYCLES_STD)
) mon (.core_clk(core_clk), .nrst(nrst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy));

`default_nettype wire

// >>> tb/eetw_bus_ctrl.sv
// Purpose: behavioural two-wire bus controller
// Assumes: data line resolved outside with a pull-up
// Notes: phases of 240 ns, far above the filter width yet short for runtime
`timescale 1ns/1ps
`default_nettype none

module eetw_bus_ctrl (
   // resolved data line
   input wire logic sdaLine,
   // controller drives
   output logic scl,
   output logic sdaDrv
);
   localparam time T = 240;

   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic start();
      sdaDrv = 1'b1;
      #T;
      scl = 1'b1;
      #T;
      sdaDrv = 1'b0;
      #T;
      scl = 1'b0;
   endtask

   task automatic stop();
      sdaDrv = 1'b0;
      #T;
      scl = 1'b1;
      #T;
      sdaDrv = 1'b1;
      #T;
   endtask

   // g puts a 36 ns low spike on the data line while the clock is high
   task automatic sendBit(input logic b, input logic g, output logic s);
      sdaDrv = b;
      #T;
      scl = 1'b1;
      #(T / 4);
      if (g) begin
         sdaDrv = 1'b0;
         #36;
         sdaDrv = 1'b1;
      end
      #(T * 3 / 4);
      s = sdaLine;
      scl = 1'b0;
   endtask

   // ackIn high releases the line on the 9th clock
   task automatic xfer(input logic [7:0] d, input logic ackIn, input logic g,
         output logic [7:0] q, output logic ackOut);
      for (int i = 7; i >= 0; i--) begin
         sendBit(d[i], g && i == 7, q[i]);
      end
      sendBit(ackIn, 1'b0, ackOut);
   endtask
endmodule // eetw_bus_ctrl

`default_nettype wire

// >>> tb/eeprom_two_wire_addressing_test.sv
// Purpose: scenario bench for the two-wire EEPROM target
// Assumes: write cycle shortened to 400 core cycles
// Notes: memory has no reset, so reads only touch written bytes
`timescale 1ns/1ps
`default_nettype none

module eeprom_two_wire_addressing_test;
   import eetw_pkg::*;
   localparam logic [3:0] TID = 4'hc; // arbitrary type identifier
   localparam int WC = 400;
   logic core_clk, linkClk, nrst, sdaOut, sdaOe, writeBusy, scl, sdaDrv;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   wire logic sdaLine = sdaDrv & (sdaOe | sdaOut);

   eetw_two_wire_target #(.TYPE_ID(TID), .WRITE_CYCLES_STD(WC), .WRITE_CYCLES_LV(WC)) dut (
      .core_clk(core_clk), .nrst(nrst), .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy));
   eetw_bus_ctrl ctrl (.sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      linkClk = 1'b0;
      #3.7;
      forever #6 linkClk = ~linkClk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         $display("CHECK FAILED run length expected finish seen hang");
         summarize();
      end
   end

   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   function automatic logic [7:0] adr(input logic [2:0] blk, input logic rd);
      return {TID, blk, rd};
   endfunction

   // lvl is the line level expected on the 9th clock, 0 means acked
   task automatic wr(input logic [7:0] d, input logic lvl, input string what);
      logic [7:0] q;
      logic a;
      ctrl.xfer(d, 1'b1, 1'b0, q, a);
      check(what, {7'h0, lvl}, {7'h0, a});
   endtask

   task automatic rd(input logic [7:0] e, input logic ackIn, input string what);
      logic [7:0] q;
      logic a;
      ctrl.xfer(8'hff, ackIn, 1'b0, q, a);
      check(what, e, q);
   endtask

   task automatic waitBusy(input logic v, input int n);
      int k;
      k = 0;
      while (writeBusy !== v && k < n) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      check("write busy", {7'h0, v}, {7'h0, writeBusy});
   endtask

   task automatic rr(input logic [2:0] blk, input logic [7:0] w, input logic [7:0] e);
      ctrl.start();
      wr(adr(blk, 1'b0), 1'b0, "addr w");
      wr(w, 1'b0, "word");
      ctrl.start();
      wr(adr(blk, 1'b1), 1'b0, "addr r");
      rd(e, 1'b1, "byte");
      ctrl.stop();
   endtask

   task automatic t_page_write();
      ctrl.start();
      wr(adr(3'h5, 1'b0), 1'b0, "addr");
      wr(8'h3e, 1'b0, "word");
      wr(8'ha1, 1'b0, "data0");
      wr(8'ha2, 1'b0, "data1");
      wr(8'ha3, 1'b0, "data2");
      ctrl.stop();
      waitBusy(1'b1, 50);
      ctrl.start();
      wr(adr(3'h5, 1'b1), 1'b1, "busy addr");
      ctrl.stop();
      waitBusy(1'b0, WC + 100);
   endtask

   task automatic t_block_write();
      ctrl.start();
      wr(adr(3'h2, 1'b0), 1'b0, "addr");
      wr(8'h3f, 1'b0, "word");
      wr(8'h5c, 1'b0, "data");
      ctrl.stop();
      waitBusy(1'b1, 50);
      waitBusy(1'b0, WC + 100);
   endtask

   task automatic t_read_back();
      ctrl.start();
      wr(adr(3'h5, 1'b0), 1'b0, "addr w");
      wr(8'h3e, 1'b0, "word");
      ctrl.start();
      wr(adr(3'h5, 1'b1), 1'b0, "addr r");
      rd(8'ha1, 1'b0, "seq0");
      rd(8'ha2, 1'b1, "seq1");
      rd(8'hff, 1'b1, "after nack");
      ctrl.stop();
      rr(3'h5, 8'h30, 8'ha3);
      rr(3'h2, 8'h3f, 8'h5c);
   endtask

   task automatic t_foreign_type();
      for (int i = 0; i < 4; i++) begin
         ctrl.start();
         wr({TID ^ (4'h1 << i), 3'h5, 1'b0}, 1'b1, "foreign type");
         ctrl.stop();
      end
   endtask

   task automatic t_restart_mid();
      logic s;
      ctrl.start();
      for (int i = 0; i < 4; i++) begin
         ctrl.sendBit(1'b1, 1'b0, s);
      end
      ctrl.start();
      wr(adr(3'h5, 1'b0), 1'b0, "addr after restart");
      wr(8'h30, 1'b0, "word after restart");
      ctrl.stop();
      repeat (100) @(posedge core_clk);
      check("no write cycle", 8'h0, {7'h0, writeBusy});
   endtask

   task automatic t_glitch();
      logic [7:0] q;
      logic a;
      ctrl.start();
      ctrl.xfer(adr(3'h5, 1'b0), 1'b1, 1'b1, q, a);
      check("addr with spike", 8'h0, {7'h0, a});
      ctrl.stop();
   endtask

   initial begin
      nrst = 1'b0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (10) @(posedge core_clk);
      t_page_write();
      t_block_write();
      t_read_back();
      t_foreign_type();
      t_restart_mid();
      t_glitch();
      summarize();
   end
endmodule // eeprom_two_wire_addressing_test

`default_nettype wire
